// ==== common/dfp_pkg.sv ====
/*
  dfp_pkg: shared constants and types for the selectable single-bit
  register cell (variant selection, force timing, power-up values).
  assumes: compiled before any design file that names dfp_pkg.
*/
package dfp_pkg;

  // which register cell the top module builds
  typedef enum logic [1:0] {
    reset_flop_variant,          // rising edge, active-low clear
    set_flop_variant,            // rising edge, active-low set
    negedge_enable_preset_flop   // falling edge, enable, sync preset
  } dfp_variant_t;

  // when an asserted clear or set reaches the output
  typedef enum logic {
    force_unclocked,             // at once, without a clock edge
    force_clocked                // at the next active clock edge
  } dfp_force_timing_t;

  // power-up values per variant
  localparam logic RESET_FLOP_INIT   = 1'b0;
  localparam logic SET_FLOP_INIT     = 1'b1;
  localparam logic NEGEDGE_FLOP_INIT = 1'b1;

  // value the output is forced to by each force input
  localparam logic CLEAR_FORCE_VALUE  = 1'b0;
  localparam logic SET_FORCE_VALUE    = 1'b1;
  localparam logic PRESET_FORCE_VALUE = 1'b1;

  // cycles from a clocked force to the output
  localparam int CLOCKED_FORCE_CYCLES = 1;

endpackage

// ==== design/dfp_flop_top.sv ====
/*
  dfp_flop_top: selectable single-bit register cell for fabric logic.
  one of three cells is built at design time: rising-edge with clear,
  rising-edge with set, or falling-edge with enable and sync preset.
  assumes: all inputs come from logic on mclk; reset_n stands for the
  initial application of power and loads the power-up value.
*/
// What this block does
// - low clear forces output low, overriding all but reset_n
// - clear high: load data on rising edge
// - power-up value of clear cell, default zero
// - clocked mode: clear acts at next edge
// - low set wins, drives output high
// - unclocked set drives one without clock
// - clocked set drives one at next edge
// - set high: load data on rising edge
// - power-up value of set cell, default one
// - preset low, enable high: one at falling edge
// - preset high: load data only when enabled
// - enable low: output holds against all inputs but reset_n
// - power-up value of falling cell, default one
`timescale 1ns/1ps

module dfp_flop_top #(
  parameter dfp_pkg::dfp_variant_t      VARIANT             = dfp_pkg::reset_flop_variant,
  parameter dfp_pkg::dfp_force_timing_t FORCE_TIMING_SELECT = dfp_pkg::force_unclocked,
  parameter logic                       POWERUP_VALUE       =
    (VARIANT == dfp_pkg::reset_flop_variant) ? dfp_pkg::RESET_FLOP_INIT :
    (VARIANT == dfp_pkg::set_flop_variant)   ? dfp_pkg::SET_FLOP_INIT   :
                                               dfp_pkg::NEGEDGE_FLOP_INIT
) (
  input  wire logic mclk,              // cell clock
  input  wire logic reset_n,           // power-up load, active low
  input  wire logic data_in,           // data input
  input  wire logic clear_active_low,  // clear, reset cell only
  input  wire logic set_active_low,    // set, set cell only
  input  wire logic preset_active_low, // sync preset, falling cell only
  input  wire logic clock_enable,      // enable, falling cell only
  output logic      q_out              // registered output
);

  // each generate branch below builds exactly one cell and drives q_out;
  // storage of the cells not chosen is never built, so nothing idles

  // variant selection at design time
  generate
    if (VARIANT == dfp_pkg::reset_flop_variant) begin : g_reset
      // rising cell forced low by clear
      dfp_rise_cell #(
        .FORCE_VALUE   (dfp_pkg::CLEAR_FORCE_VALUE),
        .FORCE_TIMING  (FORCE_TIMING_SELECT),
        .POWERUP_VALUE (POWERUP_VALUE)
      ) u_cell (
        .mclk             (mclk),
        .reset_n          (reset_n),
        .data_in          (data_in),
        .force_active_low (clear_active_low),
        .q_out            (q_out)
      );
    end else if (VARIANT == dfp_pkg::set_flop_variant) begin : g_set
      // rising cell forced high by set
      dfp_rise_cell #(
        .FORCE_VALUE   (dfp_pkg::SET_FORCE_VALUE),
        .FORCE_TIMING  (FORCE_TIMING_SELECT),
        .POWERUP_VALUE (POWERUP_VALUE)
      ) u_cell (
        .mclk             (mclk),
        .reset_n          (reset_n),
        .data_in          (data_in),
        .force_active_low (set_active_low),
        .q_out            (q_out)
      );
    end else begin : g_negedge
      logic neg_q_reg; // falling-edge cell storage

      // falling-edge cell: enable first, then preset, then data
      always_ff @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          neg_q_reg <= POWERUP_VALUE;
        end else if (!clock_enable) begin
          neg_q_reg <= neg_q_reg;
        end else if (!preset_active_low) begin
          neg_q_reg <= dfp_pkg::PRESET_FORCE_VALUE;
        end else begin
          neg_q_reg <= data_in;
        end
      end

      // preset is synchronous, so q_out moves only on a falling edge of mclk or when reset_n falls
      assign q_out = neg_q_reg;
    end
  endgenerate

  // checks on q_out, one group per variant; each group looks at the inputs
  // that its cell reads, and the set group's power-up check also at the clear

  // two consecutive rising edges with the clear released
  sequence clear_released_s;
    clear_active_low ##1 clear_active_low;
  endsequence

  // two consecutive rising edges with the set released
  sequence set_released_s;
    set_active_low ##1 set_active_low;
  endsequence

  // enabled falling edge with preset released
  sequence enabled_load_s;
    clock_enable && preset_active_low;
  endsequence

  // first rising edge after release with no force pending
  sequence rise_powerup_s;
    $rose(reset_n) && clear_active_low && set_active_low;
  endsequence

  // clear held low over two rising edges
  sequence clear_held_s;
    !clear_active_low ##1 !clear_active_low;
  endsequence

  // set held low over two rising edges
  sequence set_held_s;
    !set_active_low ##1 !set_active_low;
  endsequence

  // enabled falling edge with preset low against data zero
  sequence preset_over_data_s;
    clock_enable && !preset_active_low && !data_in;
  endsequence

  // output high at this edge and low at the next
  sequence q_falls_s;
    q_out ##1 !q_out;
  endsequence

  // output low at this edge and high at the next
  sequence q_rises_s;
    !q_out ##1 q_out;
  endsequence

  generate
    if (VARIANT == dfp_pkg::reset_flop_variant) begin : g_chk_reset
      if (FORCE_TIMING_SELECT == dfp_pkg::force_unclocked) begin : g_unclk
        // unclocked: q already low at the edge after clear falls
        clear_async_a: assert property (
          @(posedge mclk) disable iff (!reset_n)
          !clear_active_low |-> (q_out == 1'b0))
          else $error("clear low but output not low");
      end else begin : g_clk
        // clocked: a high q survives until the edge, then drops
        clear_clocked_a: assert property (
          @(posedge mclk) disable iff (!reset_n)
          (!clear_active_low && q_out) |-> q_falls_s)
          else $error("clocked clear did not act at next edge");
      end
      // clear held over an edge keeps q low in both timing modes
      clear_held_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        clear_held_s |-> !q_out)
        else $error("clear held low but output not low");
      // released clear: q follows data one edge later
      clear_load_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        clear_released_s |-> (q_out == $past(data_in)))
        else $error("reset cell did not load data");
      // power-up value still stands at the first edge
      clear_powerup_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> (q_out == POWERUP_VALUE))
        else $error("reset cell power-up value wrong");
    end else if (VARIANT == dfp_pkg::set_flop_variant) begin : g_chk_set
      if (FORCE_TIMING_SELECT == dfp_pkg::force_unclocked) begin : g_unclk
        // unclocked: q already high at the edge after set falls
        set_async_a: assert property (
          @(posedge mclk) disable iff (!reset_n)
          !set_active_low |-> q_out)
          else $error("set low but output not high");
        // data zero across an edge cannot pull q down
        set_priority_a: assert property (
          @(posedge mclk) disable iff (!reset_n)
          (!set_active_low && !data_in) ##1 !set_active_low |-> q_out)
          else $error("data overrode the set");
      end else begin : g_clk
        // clocked: a low q survives until the edge, then rises
        set_clocked_a: assert property (
          @(posedge mclk) disable iff (!reset_n)
          (!set_active_low && !q_out) |-> q_rises_s)
          else $error("clocked set did not act at next edge");
      end
      // set held over an edge keeps q high in both timing modes
      set_held_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        set_held_s |-> q_out)
        else $error("set held low but output not high");
      // released set: q follows data one edge later
      set_load_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        set_released_s |-> (q_out == $past(data_in)))
        else $error("set cell did not load data");
      // power-up value still stands at the first edge
      set_powerup_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        rise_powerup_s |-> (q_out == POWERUP_VALUE))
        else $error("set cell power-up value wrong");
    end else begin : g_chk_neg
      // preset wins over data zero at an enabled falling edge
      preset_data_a: assert property (
        @(negedge mclk) disable iff (!reset_n)
        preset_over_data_s |=> q_out)
        else $error("data overrode the preset");
      // enabled preset drives one at the falling edge
      preset_enabled_a: assert property (
        @(negedge mclk) disable iff (!reset_n)
        (clock_enable && !preset_active_low) |=> q_out)
        else $error("preset did not drive one");
      // enabled edge with preset released loads data
      enable_load_a: assert property (
        @(negedge mclk) disable iff (!reset_n)
        enabled_load_s |=> (q_out == $past(data_in)))
        else $error("enabled falling edge did not load data");
      // disabled edge leaves q where it was
      enable_hold_a: assert property (
        @(negedge mclk) disable iff (!reset_n)
        !clock_enable |=> $stable(q_out))
        else $error("output moved while enable low");
      // power-up value still stands at the first falling edge
      neg_powerup_a: assert property (
        @(negedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> (q_out == POWERUP_VALUE))
        else $error("falling cell power-up value wrong");
    end
  endgenerate

endmodule

// ==== design/dfp_rise_cell.sv ====
/*
  dfp_rise_cell: one rising-edge d register with an active-low force
  input that drives the output to a fixed value, either at once or at
  the next rising edge.
  assumes: data_in and force_active_low come from logic on mclk; in
  unclocked mode the force input must be glitch free.
*/
`timescale 1ns/1ps

module dfp_rise_cell #(
  parameter logic                        FORCE_VALUE   = 1'b0,
  parameter dfp_pkg::dfp_force_timing_t  FORCE_TIMING  = dfp_pkg::force_unclocked,
  parameter logic                        POWERUP_VALUE = 1'b0
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic data_in,
  input  wire logic force_active_low,
  output logic      q_out
);

  logic q_reg; // stored bit

  generate
    if (FORCE_TIMING == dfp_pkg::force_unclocked) begin : g_async
      // force acts without the clock and overrides data and clock
      always_ff @(posedge mclk or negedge reset_n or negedge force_active_low) begin
        if (!reset_n) begin
          q_reg <= POWERUP_VALUE;        // power-up value
        end else if (!force_active_low) begin
          q_reg <= FORCE_VALUE;
        end else begin
          q_reg <= data_in;              // load on rising edge
        end
      end
    end else begin : g_sync
      // force is only sampled on the rising edge
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          q_reg <= POWERUP_VALUE;        // power-up value
        end else if (!force_active_low) begin
          q_reg <= FORCE_VALUE;
        end else begin
          q_reg <= data_in;              // load on rising edge
        end
      end
    end
  endgenerate

  assign q_out = q_reg;

endmodule

// ==== test/dfp_fabric_model.sv ====
/*
  dfp_fabric_model: fabric logic that feeds the register cells.
  assumes: one clock, mclk; levels change 1 ns after a rising edge.
*/
`timescale 1ns/1ps

module dfp_fabric_model (
  input  wire logic mclk,              // cell clock
  output logic      data_in,           // data level
  output logic      clear_active_low,  // clear, released high
  output logic      set_active_low,    // set, released high
  output logic      preset_active_low, // preset, released high
  output logic      clock_enable       // enable, on while idle
);
  // idle levels from time zero: forces off, enable on
  initial begin
    data_in           = 1'b0;
    clear_active_low  = 1'b1;
    set_active_low    = 1'b1;
    preset_active_low = 1'b1;
    clock_enable      = 1'b1;
  end

  // new levels just after a rising edge, held until the next call
  task automatic drive(input logic d, input logic c, input logic s,
                       input logic p, input logic e);
    @(posedge mclk);
    #1;
    data_in           = d;
    clear_active_low  = c;
    set_active_low    = s;
    preset_active_low = p;
    clock_enable      = e;
  endtask
endmodule

// ==== test/tb.sv ====
/*
  tb: five register cells side by side, one per variant and timing.
  assumes: the fabric model drives all shared inputs off the edges.
*/
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  $display("wrong value %s expected %b seen %b", nm, ex, got); error_cnt++; end end

module tb;
  logic       mclk;    // 125 MHz clock
  logic       reset_n; // power-up load
  logic       d, c, s, p, e;
  logic [4:0] q;       // 0 clr/unclk 1 clr/clk 2 set/unclk 3 set/clk 4 falling
  int         error_cnt = 0;
  int         checks    = 0;

  // cell table: variant and force timing per lane
  localparam dfp_pkg::dfp_variant_t VAR_TBL [5] = '{dfp_pkg::reset_flop_variant,
    dfp_pkg::reset_flop_variant, dfp_pkg::set_flop_variant, dfp_pkg::set_flop_variant,
    dfp_pkg::negedge_enable_preset_flop};
  localparam dfp_pkg::dfp_force_timing_t TIM_TBL [5] = '{dfp_pkg::force_unclocked,
    dfp_pkg::force_clocked, dfp_pkg::force_unclocked, dfp_pkg::force_clocked,
    dfp_pkg::force_unclocked};

  dfp_fabric_model i_dfp_fabric_model (.mclk(mclk), .data_in(d), .clear_active_low(c),
    .set_active_low(s), .preset_active_low(p), .clock_enable(e));

  // one cell per lane, power-up values left at their defaults
  for (genvar i = 0; i < 5; i++) begin : g_cell
    dfp_flop_top #(.VARIANT(VAR_TBL[i]), .FORCE_TIMING_SELECT(TIM_TBL[i])) i_dfp_flop_top (
      .mclk(mclk), .reset_n(reset_n), .data_in(d), .clear_active_low(c),
      .set_active_low(s), .preset_active_low(p), .clock_enable(e), .q_out(q[i]));
  end

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // one rising edge passes, look just after it
  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  // power-up values seen right after reset release
  task automatic t_powerup();
    `CHK("powerup", 5'h1c, q)
    $display("test powerup done");
  endtask

  // plain data loads, both levels, all lanes
  task automatic t_data();
    i_dfp_fabric_model.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    step();
    `CHK("load one", 5'h1f, q)
    i_dfp_fabric_model.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    step();
    `CHK("load zero", 5'h00, q)
    $display("test data done");
  endtask

  // clear against data one: at once or at the next edge
  task automatic t_clear();
    i_dfp_fabric_model.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    i_dfp_fabric_model.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    #1;
    `CHK("clear early", 2'h2, q[1:0])
    step();
    `CHK("clear edge", 5'h1c, q)
    $display("test clear done");
  endtask

  // set against data zero: at once or at the next edge
  task automatic t_set();
    i_dfp_fabric_model.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    i_dfp_fabric_model.drive(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    #1;
    `CHK("set early", 2'h1, q[3:2])
    step();
    `CHK("set edge", 5'h0c, q)
    $display("test set done");
  endtask

  // falling cell: hold while disabled, preset only at the falling edge
  task automatic t_neg();
    i_dfp_fabric_model.drive(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    step();
    `CHK("hold disabled", 1'b0, q[4])
    i_dfp_fabric_model.drive(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    #1;
    `CHK("preset waits", 1'b0, q[4])
    step();
    `CHK("preset edge", 1'b1, q[4])
    i_dfp_fabric_model.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    step();
    `CHK("data after preset", 1'b0, q[4])
    $display("test negedge done");
  endtask

  // counts, verdict, end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog: the tests need some twenty cycles, allow ten times that
  initial begin
    #1600;
    error_cnt++;
    final_report();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    t_powerup();
    t_data();
    t_clear();
    t_set();
    t_neg();
    final_report();
  end
endmodule
